// File: core/byte_fifo.sv
`timescale 1ns/1ns
module byte_fifo
    import twi_master_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and control
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // Filling side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Draining side
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [PW:0]                 count;
        logic                        not_full;
    } fifo_state_t;

    fifo_state_t s;
    fifo_state_t next_s;
    logic        push;
    logic        pop;

    always_comb begin
        next_s = s;
        push   = in_valid && s.not_full;
        pop    = out_ready && (s.count != '0);
        if (push) begin
            next_s.mem[s.wr_ptr] = in_data;
            next_s.wr_ptr = (s.wr_ptr == PW'(DEPTH - 1)) ? '0
                                                         : s.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_s.rd_ptr = (s.rd_ptr == PW'(DEPTH - 1)) ? '0
                                                         : s.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_s.count = s.count + 1'b1;
        end else if (pop && !push) begin
            next_s.count = s.count - 1'b1;
        end
        // Registered so that the source sees a clean ready.
        next_s.not_full = (next_s.count != (PW+1)'(DEPTH));
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s          <= '0;
            s.not_full <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign in_ready  = s.not_full;
    assign out_valid = (s.count != '0);
    assign out_data  = s.mem[s.rd_ptr];

endmodule : byte_fifo

// File: core/line_sync.sv
`timescale 1ns/1ns
module line_sync
    import twi_master_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // Clock and control
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // Lines
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    // Released lines idle high, so reset to high to avoid a false edge.
    always_comb begin
        next_s        = s;
        next_s.meta   = async_in;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s <= '1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign sync_out = s.stable;

endmodule : line_sync

// File: core/twi_master_pkg.sv
package twi_master_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 20;
    // The fastest bit that the bus allows, as a period in ns (400 kbit/s).
    localparam int BIT_MIN_NS    = 2500;
    // Each bit is four quarters; a least time rounds up.
    localparam int QTR_MIN_CYCLES_I =
        (BIT_MIN_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    localparam logic [15:0] QTR_MIN_CYCLES = 16'(QTR_MIN_CYCLES_I);

    // ==========================================================
    // Widths and constants
    // ==========================================================
    localparam int          BYTE_W       = 8;
    localparam int          ADDR_W       = 7;
    localparam int          LEN_W        = 8;
    localparam int          FIFO_DEPTH   = 4;
    localparam logic [2:0]  BIT_LAST     = 3'h7;
    localparam logic [1:0]  PH_LAST      = 2'h3;
    localparam logic        DIR_WRITE    = 1'b0;
    localparam logic        DIR_READ     = 1'b1;

    // ==========================================================
    // Sequencer states
    // ==========================================================
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_START = 7'b0000010,
        ST_TX    = 7'b0000100,
        ST_RACK  = 7'b0001000,
        ST_RX    = 7'b0010000,
        ST_MACK  = 7'b0100000,
        ST_STOP  = 7'b1000000
    } state_t;

endpackage : twi_master_pkg

// File: core/two_wire_bus_master.sv
`timescale 1ns/1ns
module two_wire_bus_master
    import twi_master_pkg::*;
(
    // Clock and control
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // Bit rate: clock cycles per quarter bit
    input  wire logic [15:0]       qtr_div,
    // Command
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic              cmd_read,
    input  wire logic [LEN_W-1:0]  cmd_len,
    // Write data
    input  wire logic [BYTE_W-1:0] wr_data,
    input  wire logic              wr_valid,
    output logic                   wr_ready,
    // Read data and status
    output logic      [BYTE_W-1:0] rd_data,
    output logic                   rd_valid,
    output logic                   busy,
    output logic                   done,
    output logic                   nack,
    // Serial clock line
    input  wire logic              scl_in,
    output logic                   scl_out,
    output logic                   scl_oe_n,
    // Serial data line
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_n
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        state_t              st;
        logic [1:0]          ph;
        logic [15:0]         tmr;
        logic [BYTE_W-1:0]   sh;
        logic [2:0]          bit_cnt;
        logic [LEN_W-1:0]    left;
        logic                rd;
        logic                scl_oe_n;
        logic                sda_oe_n;
        logic                line_lo;
        logic [BYTE_W-1:0]   rd_data;
        logic                rd_valid;
        logic                done;
        logic                nack;
        logic                busy;
        logic                cmd_ready;
    } master_state_t;

    master_state_t s;
    master_state_t next_s;

    logic [1:0]        lines_s;
    logic              scl_s;
    logic              sda_s;
    logic [BYTE_W-1:0] fifo_data;
    logic              fifo_valid;
    logic              fifo_pop;
    logic [15:0]       reload;
    logic              tick;
    logic              waiting;

    // ==========================================================
    // Line sampling and write buffer
    // ==========================================================
    line_sync #(
        .WIDTH    (2)
    ) i_line_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .ce       (ce),
        .async_in ({scl_in, sda_in}),
        .sync_out (lines_s)
    );

    assign scl_s = lines_s[1];
    assign sda_s = lines_s[0];

    byte_fifo #(
        .WIDTH     (BYTE_W),
        .DEPTH     (FIFO_DEPTH)
    ) i_byte_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_data   (wr_data),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // ==========================================================
    // Bit sequencer
    // ==========================================================
    always_comb begin
        next_s          = s;
        next_s.rd_valid = 1'b0;
        next_s.done     = 1'b0;
        fifo_pop        = 1'b0;
        // A request faster than the bus allows is clamped to the limit.
        reload = (qtr_div < QTR_MIN_CYCLES) ? QTR_MIN_CYCLES - 16'h0001
                                            : qtr_div - 16'h0001;
        tick = (s.tmr == 16'h0000);
        // While the clock is released, count only once it reads high.
        waiting = s.scl_oe_n && !scl_s && (s.st != ST_IDLE);

        if (waiting) begin
            next_s.tmr = reload;
        end else if (!tick) begin
            next_s.tmr = s.tmr - 16'h0001;
        end else begin
            // Rate is taken afresh each quarter, so it may change anytime.
            next_s.tmr = reload;
            next_s.ph  = s.ph + 2'h1;
            unique case (s.st)
                ST_IDLE: begin
                    next_s.tmr = 16'h0000;
                    next_s.ph  = 2'h0;
                    if (cmd_valid) begin
                        next_s.sh = {cmd_addr, cmd_read};
                        next_s.rd        = cmd_read;
                        next_s.left      = cmd_len;
                        next_s.nack      = 1'b0;
                        next_s.busy      = 1'b1;
                        next_s.cmd_ready = 1'b0;
                        next_s.tmr       = reload;
                        next_s.st        = ST_START;
                    end
                end
                ST_START: begin
                    // Clock stays released through phases 0 to 2.
                    if (s.ph == 2'h1) begin
                        next_s.sda_oe_n = 1'b0;
                    end else if (s.ph == 2'h2) begin
                        next_s.scl_oe_n = 1'b0;
                    end else if (s.ph == PH_LAST) begin
                        next_s.bit_cnt = BIT_LAST;
                        next_s.st      = ST_TX;
                    end
                end
                ST_TX, ST_RACK, ST_RX, ST_MACK: begin
                    unique case (s.ph)
                        2'h0: begin
                            // Clock is low here, so data may move.
                            if (s.st == ST_TX) begin
                                next_s.sda_oe_n =
                                    s.sh[BYTE_W-1];
                            end else if (s.st == ST_MACK) begin
                                // Last byte read is refused to end the read.
                                next_s.sda_oe_n = (s.left == '0);
                            end else begin
                                next_s.sda_oe_n = 1'b1;
                            end
                        end
                        2'h1: begin
                            next_s.scl_oe_n = 1'b1;
                        end
                        2'h2: begin
                            if (s.st == ST_RACK) begin
                                next_s.nack = sda_s;
                            end else if (s.st == ST_RX) begin
                                next_s.sh = {s.sh[BYTE_W-2:0],
                                             sda_s};
                            end
                            next_s.scl_oe_n = 1'b0;
                        end
                        default: begin
                            next_s.ph = 2'h0;
                            if (s.st == ST_TX) begin
                                next_s.sh = {s.sh[BYTE_W-2:0], 1'b0};
                                if (s.bit_cnt == 3'h0) begin
                                    next_s.st = ST_RACK;
                                end else begin
                                    next_s.bit_cnt = s.bit_cnt - 3'h1;
                                end
                            end else if (s.st == ST_RX) begin
                                if (s.bit_cnt == 3'h0) begin
                                    next_s.rd_data  = s.sh;
                                    next_s.rd_valid = 1'b1;
                                    next_s.left     = s.left - 1'b1;
                                    next_s.st       = ST_MACK;
                                end else begin
                                    next_s.bit_cnt = s.bit_cnt - 3'h1;
                                end
                            end else if (s.st == ST_MACK) begin
                                next_s.bit_cnt = BIT_LAST;
                                next_s.st = (s.left == '0) ? ST_STOP : ST_RX;
                            end else if (s.nack || s.left == '0) begin
                                next_s.st = ST_STOP;
                            end else if (s.rd) begin
                                next_s.bit_cnt = BIT_LAST;
                                next_s.st      = ST_RX;
                            end else if (fifo_valid) begin
                                fifo_pop       = 1'b1;
                                next_s.sh      = fifo_data;
                                next_s.left    = s.left - 1'b1;
                                next_s.bit_cnt = BIT_LAST;
                                next_s.st      = ST_TX;
                            end else begin
                                // No data yet: hold the clock low and wait.
                                next_s.ph  = PH_LAST;
                                next_s.tmr = 16'h0000;
                            end
                        end
                    endcase
                end
                ST_STOP: begin
                    unique case (s.ph)
                        2'h0: begin
                            next_s.sda_oe_n = 1'b0;
                        end
                        2'h1: begin
                            next_s.scl_oe_n = 1'b1;
                        end
                        2'h2: begin
                            next_s.sda_oe_n = 1'b1;
                        end
                        default: begin
                            // Last quarter is bus free time before idle.
                            next_s.ph        = 2'h0;
                            next_s.tmr       = 16'h0000;
                            next_s.busy      = 1'b0;
                            next_s.cmd_ready = 1'b1;
                            next_s.done      = 1'b1;
                            next_s.st        = ST_IDLE;
                        end
                    endcase
                end
            endcase
        end
    end

    // No arbitration: the lines are never checked for another master.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s           <= '0;
            s.st        <= ST_IDLE;
            s.scl_oe_n  <= 1'b1;
            s.sda_oe_n  <= 1'b1;
            s.cmd_ready <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign cmd_ready = s.cmd_ready;
    assign rd_data   = s.rd_data;
    assign rd_valid  = s.rd_valid;
    assign busy      = s.busy;
    assign done      = s.done;
    assign nack      = s.nack;
    // Open-drain: the pins only ever drive low, and release otherwise.
    assign scl_out   = s.line_lo;
    assign scl_oe_n  = s.scl_oe_n;
    assign sda_out   = s.line_lo;
    assign sda_oe_n  = s.sda_oe_n;

endmodule : two_wire_bus_master

// File: test/tb_two_wire_bus_master.sv
`timescale 1ns/1ns
module tb_two_wire_bus_master
    import twi_master_pkg::*;
;

    localparam int DLY   = 2;
    localparam int LIMIT = 80000;

    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic [15:0] qtr_div = 16'h0020;
    logic        cmd_valid = 1'b0;
    logic [6:0]  cmd_addr = 7'h00;
    logic        cmd_read = 1'b0;
    logic [7:0]  cmd_len = 8'h00;
    logic [7:0]  wr_data = 8'h00;
    logic        wr_valid = 1'b0;
    logic [6:0]  slv_addr = 7'h2a;
    logic        refuse = 1'b0;
    logic        saw_full = 1'b0;
    logic        cmd_ready, wr_ready, rd_valid, busy, done, nack;
    logic [7:0]  rd_data;
    logic        scl_out, scl_oe_n, sda_out, sda_oe_n, s_oe_n;
    // An enabled pin shows its out value; a released line is pulled up.
    wire         scl_line = scl_oe_n ? 1'b1 : scl_out;
    wire         sda_line = (sda_oe_n ? 1'b1 : sda_out) & s_oe_n;
    int          fails = 0;
    int          n_tests = 0;
    int          cyc = 0;
    logic [7:0]  rexp[$];
    logic [7:0]  wexp[$];

    two_wire_bus_master i_two_wire_bus_master (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .qtr_div(qtr_div),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr),
        .cmd_read(cmd_read), .cmd_len(cmd_len), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
        .rd_valid(rd_valid), .busy(busy), .done(done), .nack(nack),
        .scl_in(scl_line), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n)
    );

    twi_slave_model i_twi_slave_model (
        .scl(scl_line), .sda(sda_line), .my_addr(slv_addr),
        .refuse(refuse), .sda_oe_n(s_oe_n)
    );

    initial forever #10 clk_sys = ~clk_sys;

    // ================
    // Checking
    // ================
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_tests = n_tests + 1;
        if (seen !== want) begin
            fails = fails + 1;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, want);
        end
    endtask : check

    task automatic end_of_test;
        $display("mismatches %0d, comparisons %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (wr_valid === 1'b1 && wr_ready === 1'b0) saw_full = 1'b1;
        if (rd_valid === 1'b1) check(rd_data, rexp.pop_front());
        if (cyc == LIMIT) begin
            fails = fails + 1;
            end_of_test();
        end
    end

    always @(i_twi_slave_model.got) begin
        check(i_twi_slave_model.last, wexp.pop_front());
    end

    // ================
    // Transfers
    // ================
    // A gap before the last write byte empties the buffer mid-frame, so
    // the master must hold the clock low; the rate changes meanwhile.
    task automatic xfer(input logic [6:0] a, input logic r, input int len,
                        input logic exp_nack, input int gap);
        logic [7:0] b;
        for (int i = 0; i < len && r && !exp_nack; i++) begin
            b = 8'($urandom);
            i_twi_slave_model.tx_q.push_back(b);
            rexp.push_back(b);
        end
        @(posedge clk_sys);
        #DLY;
        qtr_div = 16'(32 + $urandom_range(15));
        cmd_valid = 1'b1;
        cmd_addr = a;
        cmd_read = r;
        cmd_len = 8'(len);
        do @(posedge clk_sys); while (cmd_ready !== 1'b1);
        #DLY;
        cmd_valid = 1'b0;
        for (int i = 0; i < len && !r; i++) begin
            b = 8'($urandom);
            if (!exp_nack) wexp.push_back(b);
            if (i == len - 1 && gap > 0) begin
                repeat (gap) @(posedge clk_sys);
                #DLY;
                ce = 1'b0;
                qtr_div = 16'h0005;
                repeat (200) @(posedge clk_sys);
                #DLY;
                ce = 1'b1;
            end
            @(posedge clk_sys);
            #DLY;
            wr_data = b;
            wr_valid = 1'b1;
            do @(posedge clk_sys); while (wr_ready !== 1'b1);
            #DLY;
            wr_valid = 1'b0;
        end
        for (int i = 0; i < 20000 && done !== 1'b1; i++) begin
            @(posedge clk_sys);
            #DLY;
        end
        check(8'(done), 8'h01);
        check(8'(nack), 8'(exp_nack));
    endtask : xfer

    initial begin
        void'($urandom(32'h8f46));
        repeat (5) @(posedge clk_sys);
        #DLY;
        rst_n = 1'b1;
        slv_addr = 7'h7f;
        xfer(7'h7f, 1'b0, 6, 1'b0, 0);
        check(8'(saw_full), 8'h01);
        slv_addr = 7'h01;
        xfer(7'h01, 1'b1, 3, 1'b0, 0);
        slv_addr = 7'h2a;
        xfer(7'h2a, 1'b0, 2, 1'b0, 4000);
        xfer(7'h55, 1'b1, 2, 1'b1, 0);
        xfer(7'h2a, 1'b0, 0, 1'b0, 0);
        refuse = 1'b1;
        xfer(7'h2a, 1'b1, 1, 1'b1, 0);
        refuse = 1'b0;
        repeat (3) begin
            slv_addr = 7'($urandom_range(127, 1));
            xfer(slv_addr, 1'b1, 1, 1'b0, 0);
        end
        check(8'(rexp.size() + wexp.size()), 8'h00);
        end_of_test();
    end
endmodule : tb_two_wire_bus_master

// File: test/twi_master_checker.sv
`timescale 1ns/1ns
module twi_master_checker
    import twi_master_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Command and status
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic busy,
    input wire logic done,
    input wire logic nack,
    input wire logic rd_valid,
    // Lines
    input wire logic scl_in,
    input wire logic scl_oe_n,
    input wire logic sda_oe_n
);
    // ================
    // Phase counters
    // ================
    // A frozen clock enable only stretches a phase, so a minimum holds.
    int hi_cnt;
    int lo_cnt;

    always_ff @(posedge clk_sys) begin
        hi_cnt <= (!rst_n || !scl_oe_n) ? 0 : hi_cnt + 1;
        lo_cnt <= (!rst_n || scl_oe_n) ? 0 : lo_cnt + 1;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // ================
    // Assertions
    // ================
    AST_IDLE_FREE: assert property (
        !busy |-> scl_oe_n && sda_oe_n && cmd_ready)
        else $error("line held while idle");
    AST_TAKE: assert property (
        cmd_valid && cmd_ready |=> busy && !cmd_ready && !nack)
        else $error("command not taken cleanly");
    AST_OPEN: assert property (
        $rose(busy) |-> (scl_oe_n && sda_oe_n) [*8]
            ##[1:300] (!sda_oe_n && scl_oe_n))
        else $error("transfer did not open with a start");
    AST_START: assert property (
        $fell(sda_oe_n) && scl_oe_n |-> scl_in ##[1:300] $fell(scl_oe_n))
        else $error("data fell with clock high outside a start");
    AST_STOP: assert property (
        $rose(sda_oe_n) && scl_oe_n |-> scl_in ##[1:300] done)
        else $error("data rose with clock high outside a stop");
    AST_CLOSE: assert property (
        $fell(busy) |-> done && scl_oe_n && sda_oe_n && $past(scl_oe_n, 8))
        else $error("transfer did not close with a stop");
    AST_DONE_END: assert property (
        done |-> !busy && $past(busy))
        else $error("done outside the end of a transfer");
    AST_RD_BYTE: assert property (
        rd_valid |-> busy && !scl_oe_n ##1 !rd_valid)
        else $error("read byte outside a low clock");
    AST_SCL_HIGH: assert property (
        $fell(scl_oe_n) |-> hi_cnt >= QTR_MIN_CYCLES_I)
        else $error("clock high phase too short");
    AST_SCL_LOW: assert property (
        $rose(scl_oe_n) |-> lo_cnt >= 2 * QTR_MIN_CYCLES_I)
        else $error("clock low phase too short");

    COV_OK: cover property (done && !nack);
    COV_NACK: cover property (done && nack);
    COV_READ: cover property (rd_valid);
endmodule : twi_master_checker

bind two_wire_bus_master twi_master_checker i_twi_master_checker (
    .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .busy(busy), .done(done), .nack(nack),
    .rd_valid(rd_valid), .scl_in(scl_in), .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n)
);

// File: test/twi_slave_model.sv
`timescale 1ns/1ns
module twi_slave_model (
    // Resolved lines
    input  wire logic       scl,
    input  wire logic       sda,
    // Behaviour
    input  wire logic [6:0] my_addr,
    input  wire logic       refuse,
    // Data pull, low pulls the line
    output logic            sda_oe_n
);
    logic [7:0] sh;
    logic [7:0] last;
    logic [7:0] tx_q[$];
    event       got;
    int         cnt;
    logic       on = 1'b0;
    logic       first;
    logic       rd;
    logic       tx;
    logic       mack;

    initial sda_oe_n = 1'b1;

    // ================
    // Framing
    // ================
    always @(negedge sda) begin
        if (scl) begin
            on = 1'b1;
            first = 1'b1;
            tx = 1'b0;
            rd = 1'b0;
            cnt = -1;
        end
    end

    always @(posedge sda) begin
        if (scl) begin
            on = 1'b0;
            sda_oe_n = 1'b1;
        end
    end

    // ================
    // Bits
    // ================
    always @(posedge scl) begin
        if (on && cnt < 8 && !tx) sh = {sh[6:0], sda};
        if (on && cnt == 8 && tx) mack = !sda;
    end

    // The answer lags the falling clock, as a slow slave would.
    always @(negedge scl) begin
        if (on) begin
            #40;
            cnt = cnt + 1;
            if (cnt == 8 && tx) begin
                sda_oe_n = 1'b1;
            end else if (cnt == 8 && first) begin
                on = sh[7:1] == my_addr && !refuse;
                rd = sh[0];
                sda_oe_n = !on;
            end else if (cnt == 8) begin
                last = sh;
                -> got;
                sda_oe_n = 1'b0;
            end else if (cnt == 9) begin
                cnt = 0;
                first = 1'b0;
                if (rd && (!tx || mack)) begin
                    tx = 1'b1;
                    sh = tx_q.pop_front();
                    sda_oe_n = sh[7];
                end else begin
                    on = on && !tx;
                    sda_oe_n = 1'b1;
                end
            end else if (tx) begin
                sda_oe_n = sh[7 - cnt];
            end
        end
    end
endmodule : twi_slave_model
